// file: src/rcsf_pkg.sv
package rcsf_pkg;

   // register offsets
   localparam logic [7:0] CORE_WORD_OFF   = 8'h83;
   localparam logic [7:0] RECORD_OFF      = 8'h8e;
   localparam logic [7:0] EVT_STAT_OFF    = 8'h90;
   localparam logic [7:0] EVT_MASK_OFF    = 8'h91;

   // core status word field positions
   localparam int         CW_HI_MSB       = 7;
   localparam int         CW_HI_LSB       = 5;
   localparam int         CW_TIMEOUT_BIT  = 4;
   localparam int         CW_SLEEP_BIT    = 3;
   localparam int         CW_LO_MSB       = 2;
   localparam int         CW_LO_LSB       = 0;

   // power reset record field positions
   localparam int         REC_PWRON_BIT   = 1;
   localparam int         REC_DIP_BIT     = 0;

   // reset values
   localparam logic [2:0] CW_HI_RST       = 3'h0;
   localparam logic [2:0] CW_LO_RST       = 3'h0;
   localparam logic       TIMEOUT_RST     = 1'b1;
   localparam logic       SLEEP_FLAG_RST  = 1'b1;
   localparam logic       PWRON_RST       = 1'b0;
   localparam logic       DIP_RST         = 1'b0;

   // event status bit positions
   localparam int         EV_DIP          = 0;
   localparam int         EV_WDOG_RESET   = 1;
   localparam int         EV_WDOG_WAKE    = 2;
   localparam int         EV_CLR_RUN      = 3;
   localparam int         EV_CLR_SLEEP    = 4;
   localparam int         EV_N            = 5;
   localparam logic [4:0] EVT_RST         = 5'h00;
   localparam logic [4:0] MASK_RST        = 5'h00;

   typedef enum logic {
      RCSF_RUN    = 1'b0,
      RCSF_ASLEEP = 1'b1
   } rcsf_mode_t;

endpackage : rcsf_pkg

// file: src/rcsf_top.sv
// Contract
// - A power-on reset sets the watchdog time-out flag to one.
// - A power-on reset sets the sleep-entered flag to one.
// - Supply dip clears the dip flag, watchdog reset clears time-out, watchdog wake clears time-out and sleep flag.
// - An external clear while running leaves time-out and sleep flags unchanged.
// - An external clear while asleep leaves time-out at one and sleep flag at zero.
// - Non-power-up resets clear the top three status bits and keep the low three.
// - Power-on reset loads the status word with bits 4 and 3 set and bits 7 to 5 clear.
// - Unused record bits 7 to 2 read zero and power-on reset clears the power-on flag.
// - Record bit 1 is the power-on flag, bit 0 the active-low supply dip flag.
// - With dip detection disabled the dip flag is not maintained.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rcsf_top #(
   parameter int P_ADDR_W = 8
) (
   input  wire logic                i_mclk,
   input  wire logic                i_rst,
   input  wire logic [P_ADDR_W-1:0] i_addr,
   input  wire logic [7:0]          i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   input  wire logic                i_supply_dip_detect_enable,
   input  wire logic                i_supply_dip_reset,
   input  wire logic                i_watchdog_timer_expire,
   input  wire logic                i_watchdog_timer_clear,
   input  wire logic                i_external_clear_pin,
   input  wire logic                i_sleep_enter,
   input  wire logic                i_wake_interrupt,
   output logic [7:0]               o_rdata,
   output logic                     o_irq,
   output logic                     o_watchdog_timeout_flag,
   output logic                     o_sleep_entered_flag,
   output logic                     o_power_on_flag,
   output logic                     o_supply_dip_flag,
   output logic                     o_asleep,
   output logic                     o_core_reset
);

   if (P_ADDR_W < 8) begin : g_bad_addr_w
      $error("rcsf_top: P_ADDR_W must be at least 8");
   end

   if (rcsf_pkg::EV_N > 8) begin : g_bad_ev_n
      $error("rcsf_top: event vector must fit one byte");
   end

   function automatic logic addr_hit(input logic [P_ADDR_W-1:0] a,
                                     input logic [7:0]          off);
      logic [P_ADDR_W-1:0] upper;
      upper    = a >> 8;
      addr_hit = (a[7:0] == off) && (upper == '0);
   endfunction : addr_hit

   logic [2:0]                cw_hi_q;
   logic [2:0]                cw_lo_q;
   logic                      timeout_q;
   logic                      sleep_flag_q;
   logic                      pwron_q;
   logic                      dip_q;
   rcsf_pkg::rcsf_mode_t      mode_q;
   logic [rcsf_pkg::EV_N-1:0] evt_q;
   logic [rcsf_pkg::EV_N-1:0] mask_q;
   logic [7:0]                rdata_q;
   logic                      irq_q;
   logic                      core_reset_q;

   logic                      dip_ev;
   logic                      wdog_rst_ev;
   logic                      wdog_wake_ev;
   logic                      clr_run_ev;
   logic                      clr_sleep_ev;
   logic                      any_reset;
   logic                      sleep_go;
   logic                      wdog_clr;
   logic                      wake_go;
   logic                      wr_core;
   logic                      wr_record;
   logic                      wr_evt;
   logic                      wr_mask;
   logic [rcsf_pkg::EV_N-1:0] ev_vec;
   logic [7:0]                core_word;
   logic [7:0]                record_word;
   logic [7:0]                evt_word;
   logic [7:0]                mask_word;

   // event decode, supply dip first
   always_comb begin
      dip_ev       = i_supply_dip_reset & i_supply_dip_detect_enable;
      wdog_rst_ev  = i_watchdog_timer_expire & (mode_q == rcsf_pkg::RCSF_RUN) & ~dip_ev;
      wdog_wake_ev = i_watchdog_timer_expire & (mode_q == rcsf_pkg::RCSF_ASLEEP) & ~dip_ev;
      clr_run_ev   = i_external_clear_pin & (mode_q == rcsf_pkg::RCSF_RUN)
                     & ~dip_ev & ~i_watchdog_timer_expire;
      clr_sleep_ev = i_external_clear_pin & (mode_q == rcsf_pkg::RCSF_ASLEEP)
                     & ~dip_ev & ~i_watchdog_timer_expire;
      any_reset    = dip_ev | wdog_rst_ev | clr_run_ev | clr_sleep_ev;
      sleep_go     = i_sleep_enter & ~any_reset & ~wdog_wake_ev;
      wdog_clr     = i_watchdog_timer_clear & ~any_reset & ~wdog_wake_ev & ~i_sleep_enter;
      wake_go      = i_wake_interrupt & (mode_q == rcsf_pkg::RCSF_ASLEEP);
   end

   always_comb begin
      ev_vec                          = '0;
      ev_vec[rcsf_pkg::EV_DIP]        = dip_ev;
      ev_vec[rcsf_pkg::EV_WDOG_RESET] = wdog_rst_ev;
      ev_vec[rcsf_pkg::EV_WDOG_WAKE]  = wdog_wake_ev;
      ev_vec[rcsf_pkg::EV_CLR_RUN]    = clr_run_ev;
      ev_vec[rcsf_pkg::EV_CLR_SLEEP]  = clr_sleep_ev;
   end

   // write decode
   always_comb begin
      wr_core   = 1'b0;
      wr_record = 1'b0;
      wr_evt    = 1'b0;
      wr_mask   = 1'b0;
      if (!i_wr) begin
         wr_core = 1'b0;
      end else if (addr_hit(i_addr, rcsf_pkg::CORE_WORD_OFF)) begin
         wr_core = 1'b1;
      end else if (addr_hit(i_addr, rcsf_pkg::RECORD_OFF)) begin
         wr_record = 1'b1;
      end else if (addr_hit(i_addr, rcsf_pkg::EVT_STAT_OFF)) begin
         wr_evt = 1'b1;
      end else if (addr_hit(i_addr, rcsf_pkg::EVT_MASK_OFF)) begin
         wr_mask = 1'b1;
      end
   end

   // read words
   always_comb begin
      core_word                                             = 8'h00;
      core_word[rcsf_pkg::CW_HI_MSB:rcsf_pkg::CW_HI_LSB]    = cw_hi_q;
      core_word[rcsf_pkg::CW_TIMEOUT_BIT]                   = timeout_q;
      core_word[rcsf_pkg::CW_SLEEP_BIT]                     = sleep_flag_q;
      core_word[rcsf_pkg::CW_LO_MSB:rcsf_pkg::CW_LO_LSB]    = cw_lo_q;
      record_word                                           = 8'h00;
      record_word[rcsf_pkg::REC_PWRON_BIT]                  = pwron_q;
      record_word[rcsf_pkg::REC_DIP_BIT]                    = dip_q;
      evt_word                                              = 8'h00;
      evt_word[rcsf_pkg::EV_N-1:0]                          = evt_q;
      mask_word                                             = 8'h00;
      mask_word[rcsf_pkg::EV_N-1:0]                         = mask_q;
   end

   // status word upper bits
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cw_hi_q <= rcsf_pkg::CW_HI_RST;
      end else if (any_reset) begin
         cw_hi_q <= rcsf_pkg::CW_HI_RST;
      end else if (wr_core) begin
         cw_hi_q <= i_wdata[rcsf_pkg::CW_HI_MSB:rcsf_pkg::CW_HI_LSB];
      end
   end

   // status word low bits
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cw_lo_q <= rcsf_pkg::CW_LO_RST;
      end else if (wr_core && !any_reset) begin
         cw_lo_q <= i_wdata[rcsf_pkg::CW_LO_MSB:rcsf_pkg::CW_LO_LSB];
      end
   end

   // watchdog time-out flag
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         timeout_q <= rcsf_pkg::TIMEOUT_RST;
      end else if (dip_ev) begin
         timeout_q <= 1'b1;
      end else if (wdog_rst_ev || wdog_wake_ev) begin
         timeout_q <= 1'b0;
      end else if (clr_sleep_ev) begin
         timeout_q <= 1'b1;
      end else if (sleep_go || wdog_clr) begin
         timeout_q <= 1'b1;
      end
   end

   // sleep-entered flag
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sleep_flag_q <= rcsf_pkg::SLEEP_FLAG_RST;
      end else if (dip_ev) begin
         sleep_flag_q <= 1'b1;
      end else if (wdog_wake_ev) begin
         sleep_flag_q <= 1'b0;
      end else if (clr_sleep_ev) begin
         sleep_flag_q <= 1'b0;
      end else if (sleep_go) begin
         sleep_flag_q <= 1'b0;
      end else if (wdog_clr) begin
         sleep_flag_q <= 1'b1;
      end
   end

   // power-on flag
   // untouched by other resets
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pwron_q <= rcsf_pkg::PWRON_RST;
      end else if (wr_record) begin
         pwron_q <= i_wdata[rcsf_pkg::REC_PWRON_BIT];
      end
   end

   // supply dip flag, active low
   // disabled dips never reach here
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         dip_q <= rcsf_pkg::DIP_RST;
      end else if (dip_ev) begin
         dip_q <= 1'b0;
      end else if (wr_record) begin
         dip_q <= i_wdata[rcsf_pkg::REC_DIP_BIT];
      end
   end

   // run or asleep
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mode_q <= rcsf_pkg::RCSF_RUN;
      end else begin
         case (mode_q)
            rcsf_pkg::RCSF_RUN: begin
               if (sleep_go) begin
                  mode_q <= rcsf_pkg::RCSF_ASLEEP;
               end
            end
            rcsf_pkg::RCSF_ASLEEP: begin
               // any reset or wake ends sleep
               if (any_reset || wdog_wake_ev || wake_go) begin
                  mode_q <= rcsf_pkg::RCSF_RUN;
               end
            end
            default: begin
               mode_q <= rcsf_pkg::RCSF_RUN;
            end
         endcase
      end
   end

   // sticky event bits, set beats clear
   for (genvar g = 0; g < rcsf_pkg::EV_N; g++) begin : g_evt
      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            evt_q[g] <= rcsf_pkg::EVT_RST[g];
         end else if (ev_vec[g]) begin
            evt_q[g] <= 1'b1;
         end else if (wr_evt && i_wdata[g]) begin
            evt_q[g] <= 1'b0;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mask_q <= rcsf_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_q <= i_wdata[rcsf_pkg::EV_N-1:0];
      end
   end

   // interrupt level
   // level lags status by a cycle
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(evt_q & mask_q);
      end
   end

   // reset pulse to the core
   // pulse marks non-power-up resets
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         core_reset_q <= 1'b0;
      end else begin
         core_reset_q <= any_reset;
      end
   end

   // read data, one cycle after strobe
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
      end else if (!i_rd) begin
         rdata_q <= 8'h00;
      end else if (addr_hit(i_addr, rcsf_pkg::CORE_WORD_OFF)) begin
         rdata_q <= core_word;
      end else if (addr_hit(i_addr, rcsf_pkg::RECORD_OFF)) begin
         rdata_q <= record_word;
      end else if (addr_hit(i_addr, rcsf_pkg::EVT_STAT_OFF)) begin
         rdata_q <= evt_word;
      end else if (addr_hit(i_addr, rcsf_pkg::EVT_MASK_OFF)) begin
         rdata_q <= mask_word;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // outputs straight from flip-flops
   assign o_rdata                 = rdata_q;
   assign o_irq                   = irq_q;
   assign o_watchdog_timeout_flag = timeout_q;
   assign o_sleep_entered_flag    = sleep_flag_q;
   assign o_power_on_flag         = pwron_q;
   assign o_supply_dip_flag       = dip_q;
   assign o_asleep                = mode_q;
   assign o_core_reset            = core_reset_q;

endmodule : rcsf_top

`default_nettype wire

// file: testbench/rcsf_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rcsf_chk #(
   parameter int P_ADDR_W = 8
) (
   input wire logic                i_mclk,
   input wire logic                i_rst,
   input wire logic [P_ADDR_W-1:0] i_addr,
   input wire logic                i_rd,
   input wire logic                i_wr,
   input wire logic                i_supply_dip_detect_enable,
   input wire logic                i_supply_dip_reset,
   input wire logic                i_watchdog_timer_expire,
   input wire logic                i_watchdog_timer_clear,
   input wire logic                i_external_clear_pin,
   input wire logic                i_sleep_enter,
   input wire logic [7:0]          o_rdata,
   input wire logic                o_irq,
   input wire logic                o_watchdog_timeout_flag,
   input wire logic                o_sleep_entered_flag,
   input wire logic                o_power_on_flag,
   input wire logic                o_supply_dip_flag,
   input wire logic                o_asleep,
   input wire logic                o_core_reset
);
   logic dv;
   logic wx;
   logic xc;
   assign dv = i_supply_dip_reset & i_supply_dip_detect_enable;
   assign wx = i_watchdog_timer_expire & !dv;
   assign xc = i_external_clear_pin & !dv & !i_watchdog_timer_expire;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_por_flags_set: assert property ($fell(i_rst) |-> o_watchdog_timeout_flag
      && o_sleep_entered_flag && !o_asleep) else $error("flags wrong after reset");
   a_por_record_clear: assert property ($fell(i_rst) |-> !o_power_on_flag
      && o_rdata == 8'h00 && !o_core_reset) else $error("record wrong after reset");
   a_dip_cause_seen: assert property (dv && !i_wr |=> !o_supply_dip_flag && o_core_reset
      && o_power_on_flag == $past(o_power_on_flag)) else $error("dip cause wrong");
   a_wdog_reset_run: assert property (wx && !o_asleep |=> !o_watchdog_timeout_flag
      && $stable(o_sleep_entered_flag) && o_core_reset) else $error("watchdog reset wrong");
   a_wdog_wake_up: assert property (wx && o_asleep |=> !o_watchdog_timeout_flag
      && !o_sleep_entered_flag && !o_asleep && !o_core_reset) else $error("wake wrong");
   a_clear_run_keep: assert property (xc && !o_asleep |=> $stable(o_watchdog_timeout_flag)
      && $stable(o_sleep_entered_flag) && o_core_reset) else $error("clear run wrong");
   a_clear_sleep_set: assert property (xc && o_asleep |=> o_watchdog_timeout_flag
      && !o_sleep_entered_flag && !o_asleep) else $error("clear in sleep wrong");
   a_flags_read_only: assert property (!(dv | i_watchdog_timer_expire | i_sleep_enter
      | i_external_clear_pin | i_watchdog_timer_clear) |=> $stable(o_watchdog_timeout_flag)
      && $stable(o_sleep_entered_flag)) else $error("flags moved without event");
   a_record_read_map: assert property (i_rd && i_addr == P_ADDR_W'(rcsf_pkg::RECORD_OFF)
      |=> o_rdata == {6'h00, $past(o_power_on_flag), $past(o_supply_dip_flag)})
      else $error("record read wrong");
   a_status_read_map: assert property (i_rd && i_addr == P_ADDR_W'(rcsf_pkg::CORE_WORD_OFF)
      |=> o_rdata[4:3] == {$past(o_watchdog_timeout_flag), $past(o_sleep_entered_flag)})
      else $error("status read wrong");
   c_dip: cover property (dv);
   c_wake: cover property (wx && o_asleep);
   c_clear_sleep: cover property (xc && o_asleep);
   c_irq: cover property (o_irq);
endmodule : rcsf_chk
bind rcsf_top rcsf_chk #(.P_ADDR_W(P_ADDR_W)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
   .i_supply_dip_detect_enable(i_supply_dip_detect_enable),
   .i_supply_dip_reset(i_supply_dip_reset), .i_watchdog_timer_expire(i_watchdog_timer_expire),
   .i_watchdog_timer_clear(i_watchdog_timer_clear),
   .i_external_clear_pin(i_external_clear_pin), .i_sleep_enter(i_sleep_enter),
   .o_rdata(o_rdata), .o_irq(o_irq), .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
   .o_sleep_entered_flag(o_sleep_entered_flag), .o_power_on_flag(o_power_on_flag),
   .o_supply_dip_flag(o_supply_dip_flag), .o_asleep(o_asleep), .o_core_reset(o_core_reset));
`default_nettype wire

// file: testbench/reset_cause_status_flags_bench.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_status_flags_bench;
   localparam logic [7:0] CW = rcsf_pkg::CORE_WORD_OFF;
   localparam logic [7:0] RC = rcsf_pkg::RECORD_OFF;
   localparam logic [7:0] ES = rcsf_pkg::EVT_STAT_OFF;
   localparam logic [7:0] EM = rcsf_pkg::EVT_MASK_OFF;
   logic       i_mclk = 1'b0;
   logic       i_rst  = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr = 1'b0;
   logic       i_rd = 1'b0;
   logic       i_en = 1'b1;
   logic [5:0] ev = 6'h00;
   logic [7:0] rdata;
   logic       irq, to, pd, por, dip, asl, crst;
   logic       m_to, m_pd, m_por, m_dip, m_asl, m_cr;
   logic [2:0] m_hi, m_lo;
   logic [4:0] m_ev, m_mk;
   logic [7:0] adr [5] = '{CW, RC, ES, EM, 8'h84};
   logic [5:0] sl [4] = '{6'h02, 6'h04, 6'h20, 6'h01};
   logic [5:0] cs [6] = '{6'h03, 6'h01, 6'h08, 6'h04, 6'h08, 6'h02};
   int         n_fail = 0;
   int         samples_checked = 0;
   rcsf_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_supply_dip_detect_enable(i_en),
      .i_supply_dip_reset(ev[0]), .i_watchdog_timer_expire(ev[1]),
      .i_external_clear_pin(ev[2]), .i_sleep_enter(ev[3]), .i_watchdog_timer_clear(ev[4]),
      .i_wake_interrupt(ev[5]), .o_rdata(rdata), .o_irq(irq), .o_watchdog_timeout_flag(to),
      .o_sleep_entered_flag(pd), .o_power_on_flag(por), .o_supply_dip_flag(dip),
      .o_asleep(asl), .o_core_reset(crst));
   always #12.5 i_mclk = ~i_mclk;
   task automatic tally_and_finish;
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic void predict(input logic [5:0] v, input logic en);
      m_cr = 1'b0;
      if (v[0] && en) begin
         {m_dip, m_to, m_pd, m_asl, m_hi, m_cr} = 8'b01100001;
         m_ev[0] = 1'b1;
      end else if (v[1] && m_asl) begin
         {m_to, m_pd, m_asl} = 3'b000;
         m_ev[2] = 1'b1;
      end else if (v[1]) begin
         {m_to, m_hi, m_cr} = 5'b00001;
         m_ev[1] = 1'b1;
      end else if (v[2]) begin
         m_ev[m_asl ? 4 : 3] = 1'b1;
         if (m_asl) {m_to, m_pd, m_asl} = 3'b100;
         {m_hi, m_cr} = 4'b0001;
      end else if (v[3]) {m_to, m_pd, m_asl} = 3'b101;
      else if (v[4]) {m_to, m_pd} = 2'b11;
      else if (v[5]) m_asl = 1'b0;
   endfunction : predict
   task automatic pulse(input logic [5:0] v, input logic en);
      @(posedge i_mclk);
      ev <= v;
      i_en <= en;
      @(posedge i_mclk);
      ev <= 6'h00;
      predict(v, en);
      #1;
      chk("core_reset", 8'(m_cr), 8'(crst));
   endtask : pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      if (a == CW) {m_hi, m_lo} = {d[7:5], d[2:0]};
      if (a == RC) {m_por, m_dip} = d[1:0];
      if (a == ES) m_ev = m_ev & ~d[4:0];
      if (a == EM) m_mk = d[4:0];
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask : rd
   task automatic settle_chk;
      repeat (2) @(posedge i_mclk);
      #1;
      chk("flags", {3'h0, m_to, m_pd, m_por, m_dip, m_asl}, {3'h0, to, pd, por, dip, asl});
      chk("irq", 8'(|(m_ev & m_mk)), 8'(irq));
      rd(CW, {m_hi, m_to, m_pd, m_lo});
      rd(RC, {6'h00, m_por, m_dip});
      rd(ES, {3'h0, m_ev});
      rd(EM, {3'h0, m_mk});
      rd(8'h84, 8'h00);
   endtask : settle_chk
   task automatic do_reset;
      i_rst <= 1'b1;
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      {m_to, m_pd, m_por, m_dip, m_asl, m_hi, m_lo, m_ev, m_mk} = {5'b11000, 16'h0000};
   endtask : do_reset
   initial begin
      repeat (20000) @(posedge i_mclk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h8210ea75));
      do_reset();
      settle_chk();
      wr(RC, 8'hff);
      wr(EM, 8'h1f);
      for (int i = 0; i < 6; i++) begin
         pulse(cs[i], i != 1);
         settle_chk();
      end
      for (int n = 0; n < 60; n++) begin
         if ($urandom_range(2) == 0) wr(adr[$urandom_range(4)], 8'($urandom));
         else if (m_asl) pulse(sl[$urandom_range(3)], 1'($urandom));
         else pulse(6'($urandom), 1'($urandom));
         settle_chk();
      end
      do_reset();
      settle_chk();
      tally_and_finish();
   end
endmodule : reset_cause_status_flags_bench
`default_nettype wire
